// >>> src/csio_pkg.sv
// Shared constants of the clocked serial port and its partner
package csio_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [15:0] SERIAL_MODE_CONTROL_ADDR = 16'h00F6;
    localparam logic [15:0] SERIAL_SHIFT_DATA_ADDR = 16'h00F7;
    localparam logic [3:0] MODE_RESET = 4'h0;
    localparam logic [7:0] DATA_RESET = 8'h00;
    // ------------------------------------------------------------
    // Mode register fields
    // ------------------------------------------------------------
    localparam int MODE_CKSEL_LSB = 0;
    localparam int MODE_CKINT_BIT = 1;
    localparam int MODE_EN_BIT = 2;
    localparam int MODE_RDY_BIT = 3;
    localparam logic [1:0] CKSEL_EXT0 = 2'h0;
    localparam logic [1:0] CKSEL_EXT1 = 2'h1;
    localparam logic [1:0] CKSEL_TMR2 = 2'h2;
    localparam logic [1:0] CKSEL_OSC16 = 2'h3;
    // ------------------------------------------------------------
    // Shift and timing
    // ------------------------------------------------------------
    localparam int DATA_BITS = 8;
    localparam logic [2:0] CNT_LOAD = 3'h7;
    localparam int OSC_DIV = 16;
    localparam int OSC_HALF = OSC_DIV / 2;
    localparam int SYS_CLK_HZ = 20_000_000;
    localparam int EXT_CLK_MAX_HZ = 250_000;
    // Least half period of the partner clock, rounded up
    localparam int EXT_HALF_CYC =
        (SYS_CLK_HZ + 2 * EXT_CLK_MAX_HZ - 1) / (2 * EXT_CLK_MAX_HZ);
endpackage

// >>> src/csio_if.sv
// Pin level wiring between the serial port and its remote partner
interface csio_if;
    // Device side drives (oe_n low = driving)
    logic p4_o, p4_oe_n;
    logic p5_o, p5_oe_n;
    logic p6_o, p6_oe_n;
    logic p7_o, p7_oe_n;
    // Partner side drives
    logic h_clk_o, h_clk_oe_n;
    logic h_sin_o, h_sin_oe_n;
    // Resolved wire levels, pulled up when undriven
    logic port3_pin4, port3_pin5, port3_pin6, port3_pin7;

    assign port3_pin4 = !p4_oe_n ? p4_o : (!h_sin_oe_n ? h_sin_o : 1'b1);
    assign port3_pin5 = !p5_oe_n ? p5_o : 1'b1;
    assign port3_pin6 = !p6_oe_n ? p6_o : (!h_clk_oe_n ? h_clk_o : 1'b1);
    assign port3_pin7 = !p7_oe_n ? p7_o : 1'b1;

    modport dev (
        output p4_o, p4_oe_n, p5_o, p5_oe_n, p6_o, p6_oe_n, p7_o, p7_oe_n,
        input port3_pin4, port3_pin5, port3_pin6, port3_pin7
    );
    modport host (
        output h_clk_o, h_clk_oe_n, h_sin_o, h_sin_oe_n,
        input port3_pin4, port3_pin5, port3_pin6, port3_pin7
    );
endinterface

// >>> src/csio_dev.sv
// Clocked serial port: CPU registers, shift logic and pin sharing
// Behaviour
// - Mode bit 2 hands clock pin to serial
// - Internal clock drives pin; external clock is input
// - Software clears data-in pin direction first
// - Serial mode sources shared interrupt from counter
// - Ready high during transfer or dummy data
// - Data write drives ready low
// - Ready returns high at next clock fall
// - Data write loads shift counter with seven
// - Fall presents bit, rise samples and shifts
// - Least significant bit first both ways
// - Internal clock stops high, raises request
// - External clock: request after eight, no gating
// - Partner clock at most 250 kHz, 50 percent
// - Mode bits 1:0 select transfer clock
// - Four-bit mode register at 00F6
// - Software sequences interrupt enable around mode
module csio_dev #(
    parameter int DATA_W = 8
) (
    input wire logic sys_clk_i,                 // System clock
    input wire logic rstn_i,                    // Async reset, active low
    input wire logic ce_i,                      // Clock enable
    input wire logic [15:0] addr_i,             // CPU address
    input wire logic [7:0] wdata_i,             // CPU write data
    input wire logic wr_i,                      // CPU write strobe
    input wire logic rd_i,                      // CPU read strobe
    output logic [7:0] rdata_o,                 // CPU read data
    input wire logic t2_ovf_i,                  // Timer 2 overflow pulse
    input wire logic t2_irq_i,                  // Timer 2 request pulse
    output logic irq_o,                         // Shared request pulse
    input wire logic [3:0] gpio_out_i,          // Port data, pins 7..4
    input wire logic [3:0] gpio_dir_i,          // Port direction, 1=out
    output logic [3:0] gpio_in_o,               // Pin levels, pins 7..4
    csio_if.dev pins                            // Port 3 pins
);
    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (DATA_W != csio_pkg::DATA_BITS) begin : g_chk
        $error("csio_dev supports only an 8-bit data register");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] mode;
        logic [7:0] shreg;
        logic [2:0] cnt;
        logic active;
        logic sclk;
        logic [2:0] div;
        logic sout;
        logic rdy_n;
        logic ext_prev;
        logic done;
        logic [7:0] rdata;
    } csio_dev_st_t;

    csio_dev_st_t r;
    csio_dev_st_t next_r;

    function automatic logic hit(input logic [15:0] a,
                                 input logic [15:0] reg_addr);
        hit = (a == reg_addr);
    endfunction

    logic en;
    logic cksel_int;
    logic [1:0] cksel;
    logic tick;
    logic fall;
    logic rise;

    assign en = r.mode[csio_pkg::MODE_EN_BIT];
    assign cksel = r.mode[csio_pkg::MODE_CKSEL_LSB +: 2];
    assign cksel_int = r.mode[csio_pkg::MODE_CKINT_BIT];

    // ------------------------------------------------------------
    // Transfer clock edges
    // ------------------------------------------------------------
    always_comb begin
        tick = 1'b0;
        if (r.active) begin
            case (cksel)
                csio_pkg::CKSEL_TMR2: tick = t2_ovf_i;
                csio_pkg::CKSEL_OSC16:
                    tick = (r.div == 3'(csio_pkg::OSC_HALF - 1));
                csio_pkg::CKSEL_EXT0,
                csio_pkg::CKSEL_EXT1: tick = 1'b0;
                default: tick = 1'b0;
            endcase
        end
        if (cksel_int) begin
            fall = tick && r.sclk;
            rise = tick && !r.sclk;
        end else begin
            // Partner clock, sampled as a plain input
            fall = en && r.ext_prev && !pins.port3_pin6;
            rise = en && !r.ext_prev && pins.port3_pin6;
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        next_r.ext_prev = pins.port3_pin6;
        if (r.active && cksel == csio_pkg::CKSEL_OSC16) begin
            next_r.div = r.div + 3'h1;
        end else begin
            next_r.div = 3'h0;
        end
        if (tick) begin
            next_r.sclk = !r.sclk;
        end
        if (en && fall) begin
            next_r.sout = r.shreg[0];
            next_r.rdy_n = 1'b1;
        end
        if (en && rise) begin
            next_r.shreg = {pins.port3_pin4, r.shreg[7:1]};
            next_r.cnt = r.cnt - 3'h1;
            if (r.cnt == 3'h0) begin
                next_r.done = 1'b1;
                next_r.active = 1'b0;
            end
        end
        if (ce_i && wr_i && hit(addr_i, csio_pkg::SERIAL_MODE_CONTROL_ADDR))
        begin
            next_r.mode = wdata_i[3:0];
        end
        if (ce_i && wr_i && hit(addr_i, csio_pkg::SERIAL_SHIFT_DATA_ADDR))
        begin
            next_r.shreg = wdata_i;
            next_r.cnt = csio_pkg::CNT_LOAD;
            next_r.rdy_n = 1'b0;
            next_r.active = en && cksel_int;
            next_r.sclk = 1'b1;
            next_r.div = 3'h0;
        end
        if (rd_i) begin
            if (hit(addr_i, csio_pkg::SERIAL_SHIFT_DATA_ADDR)) begin
                next_r.rdata = r.shreg;
            end else if (hit(addr_i, csio_pkg::SERIAL_MODE_CONTROL_ADDR))
            begin
                next_r.rdata = {4'h0, r.mode};
            end else begin
                next_r.rdata = 8'h00;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            r.mode <= csio_pkg::MODE_RESET;
            r.shreg <= csio_pkg::DATA_RESET;
            r.cnt <= csio_pkg::CNT_LOAD;
            r.active <= 1'b0;
            r.sclk <= 1'b1;
            r.div <= 3'h0;
            r.sout <= 1'b1;
            r.rdy_n <= 1'b1;
            r.ext_prev <= 1'b1;
            r.done <= 1'b0;
            r.rdata <= 8'h00;
        end else if (ce_i) begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // Pin sharing
    // ------------------------------------------------------------
    always_comb begin
        // Data in: direction stays with the port register
        pins.p4_o = gpio_out_i[0];
        pins.p4_oe_n = !gpio_dir_i[0];
        if (en) begin
            pins.p5_o = r.sout;
            pins.p5_oe_n = 1'b0;
            pins.p6_o = r.sclk;
            pins.p6_oe_n = !cksel_int;
        end else begin
            pins.p5_o = gpio_out_i[1];
            pins.p5_oe_n = !gpio_dir_i[1];
            pins.p6_o = gpio_out_i[2];
            pins.p6_oe_n = !gpio_dir_i[2];
        end
        if (r.mode[csio_pkg::MODE_RDY_BIT]) begin
            pins.p7_o = r.rdy_n;
            pins.p7_oe_n = 1'b0;
        end else begin
            pins.p7_o = gpio_out_i[3];
            pins.p7_oe_n = !gpio_dir_i[3];
        end
    end

    assign gpio_in_o = {pins.port3_pin7, pins.port3_pin6,
                        pins.port3_pin5, pins.port3_pin4};
    // Software masks the request around mode changes
    assign irq_o = en ? r.done : t2_irq_i;
    assign rdata_o = r.rdata;
endmodule

// >>> src/csio_host.sv
// Remote partner: clock master or follower of the serial port
module csio_host #(
    parameter int DATA_W = 8,
    parameter int HALF_CYC = csio_pkg::EXT_HALF_CYC
) (
    input wire logic sys_clk_i,                 // System clock
    input wire logic rstn_i,                    // Async reset, active low
    input wire logic ce_i,                      // Clock enable
    input wire logic clk_master_i,              // 1: partner makes clock
    input wire logic wait_rdy_i,                // 1: start waits for ready
    input wire logic start_i,                   // Start pulse
    input wire logic [7:0] tx_data_i,           // Byte to send
    output logic busy_o,                        // Transfer armed or running
    output logic done_o,                        // Byte complete pulse
    output logic [7:0] rx_data_o,               // Byte received
    csio_if.host pins                           // Port 3 pins
);
    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (DATA_W != csio_pkg::DATA_BITS || HALF_CYC < csio_pkg::EXT_HALF_CYC
        || HALF_CYC > 255) begin : g_chk
        $error("csio_host: 8 bits and a clock within 250 kHz only");
    end

    typedef enum logic [1:0] {IDLE, ARM, RUN} csio_host_state_t;
    typedef struct packed {
        csio_host_state_t st;
        logic [7:0] shreg;
        logic [3:0] bits;
        logic [7:0] hcnt;
        logic sclk;
        logic sin;
        logic prev;
        logic done;
        logic [7:0] rx;
    } csio_host_st_t;

    csio_host_st_t r;
    csio_host_st_t next_r;
    logic tick;
    logic fall;
    logic rise;

    always_comb begin
        tick = clk_master_i && r.st == RUN
            && r.hcnt == 8'(HALF_CYC - 1);
        if (clk_master_i) begin
            fall = tick && r.sclk;
            rise = tick && !r.sclk;
        end else begin
            fall = r.prev && !pins.port3_pin6;
            rise = !r.prev && pins.port3_pin6;
        end
    end

    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        next_r.prev = pins.port3_pin6;
        case (r.st)
            IDLE: begin
                next_r.hcnt = 8'h00;
                next_r.sclk = 1'b1;
                if (start_i) begin
                    // With wait_rdy_i set, start waits for the port's ready pin
                    next_r.st = (wait_rdy_i && pins.port3_pin7) ? ARM : RUN;
                    next_r.shreg = tx_data_i;
                    next_r.bits = 4'h0;
                end
            end
            ARM: begin
                next_r.hcnt = 8'h00;
                next_r.sclk = 1'b1;
                if (!pins.port3_pin7) begin
                    next_r.st = RUN;
                end
            end
            RUN: begin
                next_r.hcnt = tick ? 8'h00 : r.hcnt + 8'h01;
                if (tick) begin
                    next_r.sclk = !r.sclk;
                end
                if (fall) begin
                    next_r.sin = r.shreg[0];
                end
                if (rise) begin
                    next_r.shreg = {pins.port3_pin5, r.shreg[7:1]};
                    next_r.bits = r.bits + 4'h1;
                    if (r.bits == 4'(DATA_W - 1)) begin
                        // Clock parks high after the eighth bit
                        next_r.st = IDLE;
                        next_r.done = 1'b1;
                        next_r.rx = {pins.port3_pin5, r.shreg[7:1]};
                    end
                end
            end
            default: next_r.st = IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            r.st <= IDLE;
            r.shreg <= 8'h00;
            r.bits <= 4'h0;
            r.hcnt <= 8'h00;
            r.sclk <= 1'b1;
            r.sin <= 1'b1;
            r.prev <= 1'b1;
            r.done <= 1'b0;
            r.rx <= 8'h00;
        end else if (ce_i) begin
            r <= next_r;
        end
    end

    assign pins.h_clk_o = r.sclk;
    assign pins.h_clk_oe_n = !clk_master_i;
    assign pins.h_sin_o = r.sin;
    // Last bit held a cycle: the port sees the clock rise a cycle late
    assign pins.h_sin_oe_n = (r.st == IDLE) && !r.done;
    assign busy_o = (r.st != IDLE);
    assign done_o = r.done;
    assign rx_data_o = r.rx;
endmodule

// >>> tb/csio_chk.sv
// Pin level assertions for the serial port link
module csio_chk #(
    parameter int HALF = csio_pkg::EXT_HALF_CYC
) (
    input wire logic sys_clk_i,  // System clock
    input wire logic rstn_i,     // Async reset, active low
    input wire logic p5_oe_n,    // Device data out enable
    input wire logic p6_oe_n,    // Device clock enable
    input wire logic p7_oe_n,    // Device ready enable
    input wire logic h_clk_o,    // Partner clock
    input wire logic h_clk_oe_n, // Partner clock enable
    input wire logic h_sin_o,    // Partner data
    input wire logic h_sin_oe_n, // Partner data enable
    input wire logic port3_pin5, // Device data wire
    input wire logic port3_pin6, // Clock wire
    input wire logic port3_pin7  // Ready wire
);
    logic [3:0] rcnt;
    logic [7:0] hcnt;
    logic p6_q;
    logic hclk_q;
    logic rdy_q;
    logic p7_oe_q;
    logic rdy_win;
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rcnt <= 4'h0;
            hcnt <= 8'h00;
            p6_q <= 1'b1;
            hclk_q <= 1'b1;
            rdy_q <= 1'b1;
            p7_oe_q <= 1'b1;
            rdy_win <= 1'b0;
        end else begin
            p6_q <= port3_pin6;
            hclk_q <= h_clk_o;
            rdy_q <= port3_pin7;
            p7_oe_q <= p7_oe_n;
            // Ready window: a fall of the ready pin it already drove
            if (port3_pin7 || p7_oe_n)
                rdy_win <= 1'b0;
            else if (rdy_q && !p7_oe_q)
                rdy_win <= 1'b1;
            if (!port3_pin7)
                rcnt <= 4'h0;
            else if (!p6_oe_n && port3_pin6 && !p6_q)
                rcnt <= rcnt + 4'h1;
            if (h_clk_o != hclk_q)
                hcnt <= 8'h00;
            else if (hcnt != 8'hff)
                hcnt <= hcnt + 8'h01;
        end
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    sequence clk_low8;
        (!port3_pin6) [*8] ##1 port3_pin6;
    endsequence
    rdy_rise_fall_a: assert property ($rose(port3_pin7) && !p7_oe_n
        && $past(!p7_oe_n) |-> !port3_pin6)
        else $error("ready rose with clock high");
    rdy_hold_clk_a: assert property (rdy_win && !p6_oe_n && !port3_pin7
        |-> port3_pin6) else $error("clock moved while ready low");
    clk_low_len_a: assert property ($fell(port3_pin6) && !p6_oe_n
        && $past(!p6_oe_n) |-> clk_low8)
        else $error("internal clock low phase wrong");
    clk_high_len_a: assert property ($rose(port3_pin6) && !p6_oe_n
        |-> port3_pin6 [*8]) else $error("internal clock high too short");
    clk_count_a: assert property (rcnt <= 4'h8)
        else $error("more than eight internal clocks");
    sout_at_low_a: assert property ($changed(port3_pin5) && !p5_oe_n
        && $past(!p5_oe_n) |-> !port3_pin6)
        else $error("data out moved with clock high");
    sin_at_low_a: assert property ($changed(h_sin_o) && !h_sin_oe_n
        && $past(!h_sin_oe_n) |-> !port3_pin6)
        else $error("partner data moved with clock high");
    ext_no_fight_a: assert property (!h_clk_oe_n |-> p6_oe_n)
        else $error("both ends drive the clock");
    host_half_a: assert property ($changed(h_clk_o) && !h_clk_oe_n
        && $past(!h_clk_oe_n) |-> hcnt >= HALF - 1)
        else $error("partner half period too short");
endmodule

// >>> tb/testbench.sv
// Self-checking bench joining the serial port and its partner
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wdata = 8'h00, rdata, tx = 8'h00, rx, cap = 8'h00, r;
    logic wr = 1'b0, rd = 1'b0, t2_ovf = 1'b0, t2_irq = 1'b0, irq;
    logic master = 1'b0, start = 1'b0, done, busy, p6_q = 1'b1;
    logic [3:0] gout = 4'h0, gdir = 4'h0, gin;
    logic [2:0] tcnt = 3'h0;
    int failures = 0, n_compared = 0, n_irq = 0, seedv;
    csio_if i_csio_if ();
    csio_dev i_csio_dev (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
        .ce_i(1'b1), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .t2_ovf_i(t2_ovf), .t2_irq_i(t2_irq), .irq_o(irq),
        .gpio_out_i(gout), .gpio_dir_i(gdir), .gpio_in_o(gin),
        .pins(i_csio_if.dev));
    csio_host i_csio_host (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
        .ce_i(1'b1), .clk_master_i(master), .wait_rdy_i(master),
        .start_i(start), .tx_data_i(tx), .busy_o(busy), .done_o(done),
        .rx_data_o(rx), .pins(i_csio_if.host));
    csio_chk i_csio_chk (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
        .p5_oe_n(i_csio_if.p5_oe_n), .p6_oe_n(i_csio_if.p6_oe_n),
        .p7_oe_n(i_csio_if.p7_oe_n), .h_clk_o(i_csio_if.h_clk_o),
        .h_clk_oe_n(i_csio_if.h_clk_oe_n), .h_sin_o(i_csio_if.h_sin_o),
        .h_sin_oe_n(i_csio_if.h_sin_oe_n),
        .port3_pin5(i_csio_if.port3_pin5), .port3_pin6(i_csio_if.port3_pin6),
        .port3_pin7(i_csio_if.port3_pin7));
    always #25 sys_clk_i = ~sys_clk_i;
    // Timer overflow every eight cycles, wire capture at clock rises
    always @(posedge sys_clk_i) begin
        tcnt <= tcnt + 3'h1;
        t2_ovf <= (tcnt == 3'h7);
        p6_q <= i_csio_if.port3_pin6;
        if (i_csio_if.port3_pin6 && !p6_q)
            cap <= {i_csio_if.port3_pin5, cap[7:1]};
        if (irq === 1'b1)
            n_irq <= n_irq + 1;
    end
    function automatic logic [7:0] mode_view(input logic [3:0] m);
        return {4'h0, m};
    endfunction
    task automatic chk(input logic [7:0] got_v, input logic [7:0] exp_v);
        n_compared++;
        if (got_v !== exp_v) begin
            $display("mismatch at %0t: got %h expected %h", $time, got_v,
                exp_v);
            failures++;
        end
    endtask
    task automatic wrap_up;
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic cpu_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk_i);
        wr <= 1'b0;
    endtask
    task automatic cpu_rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge sys_clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk_i);
        rd <= 1'b0;
        @(posedge sys_clk_i);
        #1 d = rdata;
    endtask
    task automatic xfer(input logic [1:0] code);
        logic [7:0] bd, bh;
        int k, irq0;
        bd = 8'($urandom);
        bh = 8'($urandom);
        cpu_wr(16'h00f6, 8'h00);
        @(posedge sys_clk_i);
        master <= !code[1];
        cpu_wr(16'h00f6, {4'h0, 2'b11, code});
        @(posedge sys_clk_i);
        start <= 1'b1;
        tx <= bh;
        @(posedge sys_clk_i);
        start <= 1'b0;
        irq0 = n_irq;
        cpu_wr(16'h00f7, bd);
        #1 chk({7'h00, i_csio_if.port3_pin7}, 8'h00);
        chk({7'h00, busy}, 8'h01);
        k = 0;
        while (k < 3000 && done !== 1'b1) begin
            @(posedge sys_clk_i);
            #1 k++;
        end
        if (k == 3000) begin
            failures++;
            wrap_up;
        end
        repeat (4) @(posedge sys_clk_i);
        #1 chk(rx, bd);
        chk(cap, bd);
        cpu_rd(16'h00f7, r);
        chk(r, bh);
        chk(8'(n_irq - irq0), 8'h01);
        chk({6'h00, i_csio_if.port3_pin6, i_csio_if.port3_pin7}, 8'h03);
        chk({7'h00, busy}, 8'h00);
        $display("transfer with clock code %h done", code);
    endtask
    initial begin
        seedv = $urandom(32'hfeb0);
        repeat (3) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        wdata <= 8'($urandom);
        cpu_wr(16'h00f6, 8'($urandom));
        cpu_rd(16'h00f6, r);
        chk(r, mode_view(wdata[3:0]));
        cpu_rd(16'h00f5, r);
        chk(r, 8'h00);
        cpu_wr(16'h00f6, 8'h00);
        @(posedge sys_clk_i);
        gdir <= 4'hf;
        gout <= 4'($urandom);
        repeat (2) @(posedge sys_clk_i);
        #1 chk({4'h0, gin}, {4'h0, gout});
        @(posedge sys_clk_i);
        gdir <= 4'h0;
        t2_irq <= 1'b1;
        @(posedge sys_clk_i);
        #1 chk({7'h00, irq}, 8'h01);
        @(posedge sys_clk_i);
        t2_irq <= 1'b0;
        $display("register and port test done");
        for (int i = 0; i < 8; i++)
            xfer(2'(i));
        wrap_up;
    end
endmodule
